// >>> hw/osc_ctrl_pkg.sv
// constants shared by the oscillator switch control block
package osc_ctrl_pkg;
  // register offsets, printed offsets are not multiples of four: indices
  localparam logic [11:0] IDX_REQ_SRC_DIV  = 12'hE43;
  localparam logic [11:0] IDX_CUR_SRC_DIV  = 12'hE44;
  localparam logic [11:0] IDX_HOLD_STATUS  = 12'hE45;
  localparam logic [11:0] IDX_READY_FLAGS  = 12'hE46;
  localparam logic [11:0] IDX_MANUAL_EN    = 12'hE47;
  localparam logic [11:0] IDX_TRIM         = 12'hE48;
  localparam logic [11:0] IDX_FREQ_SEL     = 12'hE49;
  localparam int          ADDR_W           = 14;
  // field positions and oscillator count
  localparam int          SRC_LSB          = 4;
  localparam int          HOLD_BIT         = 7;
  localparam int          SPWR_BIT         = 6;
  localparam int          DONE_BIT         = 4;
  localparam int          NRDY_BIT         = 3;
  localparam int          OSC_NUM          = 6;
  // reset values and largest legal divider and frequency codes
  localparam logic [2:0]  SRC_RESET        = 3'h6;
  localparam logic [3:0]  DIV_RESET        = 4'h2;
  localparam logic [3:0]  FREQ_RESET       = 4'h2;
  localparam logic [5:0]  TRIM_RESET       = 6'h00;
  localparam logic [5:0]  EN_RESET         = 6'h00;
  localparam logic [3:0]  DIV_MAX          = 4'h9;
  localparam logic [3:0]  FREQ_MAX         = 4'h8;
  // source codes
  localparam logic [2:0]  SRC_EXT          = 3'h7;
  localparam logic [2:0]  SRC_FAST         = 3'h6;
  localparam logic [2:0]  SRC_SLOW         = 3'h5;
  localparam logic [2:0]  SRC_SEC          = 3'h4;
  localparam logic [2:0]  SRC_EXT_PLL      = 3'h2;
  // switch sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HELD = 2'b11
  } switch_state_t;
endpackage

// >>> hw/source_ready_mux.sv
// picks the ready indication of the requested oscillator
`timescale 1ns/1ns
module source_ready_mux (
  // request
  input  wire logic [2:0] src,
  // oscillator status
  input  wire logic       ext_ready,
  input  wire logic       fast_ready,
  input  wire logic       slow_ready,
  input  wire logic       sec_ready,
  input  wire logic       pll_ok,
  // result
  output logic            sel_ready
);
  import osc_ctrl_pkg::*;
  // reserved codes never become ready
  always_comb begin
    case (src)
      SRC_EXT:     sel_ready = ext_ready;
      SRC_FAST:    sel_ready = fast_ready;
      SRC_SLOW:    sel_ready = slow_ready;
      SRC_SEC:     sel_ready = sec_ready;
      SRC_EXT_PLL: sel_ready = pll_ok;
      default:     sel_ready = 1'b0;
    endcase
  end
endmodule // source_ready_mux

// >>> hw/osc_switch_ctrl.sv
// oscillator selection, switch handshake and status registers over apb
// Functional notes
// R1: divider code 0..9 means divide by 2**code
// R2: after reset current fields equal requested fields
// R3: current fields hold startup result at code start
// R4: hold bit pauses switch and raises interrupt
// R5: hold clear completes switch when new ready
// R6: secondary power select drives high/low power
// R7: switch complete reads one when current equals request
// R8: new ready reads one only during switch
// R9: without hold, new ready may be unseen
// R10: per oscillator ready flags, read only
// R11: pll ready zero unless enabled, sourced, locked
// R12: fast internal frequency codes, above 1000 reserved
// R13: signed six bit trim, resets to zero
// R14: external manual enable keeps it running
// R15: fast internal manual enable keeps it running
// R16: medium internal manual enable keeps it running
// R17: slow internal manual enable keeps it running
// R18: secondary manual enable keeps it running
// R19: converter manual enable keeps it running
// R20: requested source codes, reserved ones listed
// R21: reserved source write ignored entirely
// R22: switch disallowed makes request register read only
// R23: differing request starts switch, completion copies
// R24: clearing hold on ready switch completes it
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module osc_switch_ctrl (
  // apb slave
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // configuration
  input  wire logic                             switch_allow_config,
  // oscillator ready inputs, order ext fast medium slow sec conv
  input  wire logic [osc_ctrl_pkg::OSC_NUM-1:0] osc_ready_in,
  input  wire logic                             pll_enabled,
  input  wire logic                             pll_locked,
  // peripheral requests, same order
  input  wire logic [osc_ctrl_pkg::OSC_NUM-1:0] periph_request,
  // oscillator controls
  output logic      [osc_ctrl_pkg::OSC_NUM-1:0] osc_enable,
  output logic                                  secondary_high_power,
  output logic      [3:0]                       fast_internal_frequency,
  output logic      [5:0]                       fast_internal_trim_value,
  output logic      [2:0]                       current_source,
  output logic      [3:0]                       current_divider,
  output logic                                  switch_hold_irq
);
  import osc_ctrl_pkg::*;

  // request and readback state
  logic [2:0]          req_src_r;          // requested source
  logic [3:0]          req_div_r;          // requested divider
  logic [2:0]          cur_src_r;          // active source
  logic [3:0]          cur_div_r;          // active divider
  logic                hold_r;             // switch hold bit
  logic                spwr_r;             // secondary power select
  logic [OSC_NUM-1:0]  man_en_r;           // manual enables
  logic [5:0]          trim_r;             // fast internal trim
  logic [3:0]          freq_r;             // fast internal frequency
  logic [7:0]          flags_r;            // sampled ready flags
  switch_state_t       state_r;            // switch sequencer
  logic                sel_ready;          // requested osc ready
  logic                pll_ok;             // pll usable
  logic                wr_en;              // apb write strobe
  logic                rd_en;              // apb read strobe
  logic [11:0]         idx;                // register index
  logic                idx_ok;             // mapped index
  logic                switching;          // request differs

  // one wait-free access phase; index is byte address over four
  // refused addresses must not alias onto a register, so both gate on idx_ok
  assign wr_en  = psel && penable && pwrite && idx_ok;
  assign rd_en  = psel && !penable && !pwrite && idx_ok;
  assign idx    = paddr[13:2];
  assign idx_ok = (paddr[31:ADDR_W] == '0) && (paddr[1:0] == 2'b00) &&
                  (idx >= IDX_REQ_SRC_DIV) && (idx <= IDX_FREQ_SEL);
  assign switching = (req_src_r != cur_src_r) || (req_div_r != cur_div_r);

  // pll needs enable, external source ready and lock
  assign pll_ok = pll_enabled && osc_ready_in[5] && pll_locked; // see R11

  // requested-source decode used by writes and the checks
  function automatic logic src_legal(input logic [2:0] s);
    return (s == SRC_EXT) || (s == SRC_FAST) || (s == SRC_SLOW) ||
           (s == SRC_SEC) || (s == SRC_EXT_PLL); // see R20
  endfunction

  source_ready_mux u_mux (
    .src        (req_src_r),
    .ext_ready  (osc_ready_in[5]),
    .fast_ready (osc_ready_in[4]),
    .slow_ready (osc_ready_in[2]),
    .sec_ready  (osc_ready_in[1]),
    .pll_ok     (pll_ok),
    .sel_ready  (sel_ready)
  );

  // requested source and divider register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_src_r <= SRC_RESET;
      req_div_r <= DIV_RESET;
    end else if (wr_en && idx == IDX_REQ_SRC_DIV &&
                 switch_allow_config) begin // see R22
      // reserved source code drops the whole write
      if (src_legal(pwdata[6:4]) && pwdata[3:0] <= DIV_MAX) begin // see R21
        req_src_r <= pwdata[6:4];
        req_div_r <= pwdata[3:0]; // see R1
      end
    end
  end

  // switch sequencer: wait for ready, then hold or complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_IDLE;
      cur_src_r <= SRC_RESET; // see R2
      cur_div_r <= DIV_RESET; // see R3
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (switching)
            state_r <= ST_WAIT; // see R23
        end
        ST_WAIT: begin
          if (!switching)
            state_r <= ST_IDLE;
          else if (sel_ready && hold_r)
            state_r <= ST_HELD; // see R4
          else if (sel_ready) begin
            cur_src_r <= req_src_r; // see R5
            cur_div_r <= req_div_r; // see R23
            state_r   <= ST_IDLE;
          end
        end
        ST_HELD: begin
          if (!switching)
            state_r <= ST_IDLE;
          else if (!sel_ready)
            state_r <= ST_WAIT;
          else if (!hold_r) begin
            cur_src_r <= req_src_r; // see R24
            cur_div_r <= req_div_r;
            state_r   <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // hold and secondary power bits; hardware never clears hold here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 1'b0;
      spwr_r <= 1'b0;
    end else if (wr_en && idx == IDX_HOLD_STATUS) begin
      hold_r <= pwdata[HOLD_BIT];
      spwr_r <= pwdata[SPWR_BIT]; // see R6
    end
  end

  // manual enables, trim and frequency select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_en_r <= EN_RESET;
      trim_r   <= TRIM_RESET; // see R13
      freq_r   <= FREQ_RESET;
    end else if (wr_en) begin
      if (idx == IDX_MANUAL_EN)
        man_en_r <= pwdata[7:2];
      if (idx == IDX_TRIM)
        trim_r <= pwdata[5:0]; // see R13
      // reserved frequency codes are not stored
      if (idx == IDX_FREQ_SEL && pwdata[3:0] <= FREQ_MAX)
        freq_r <= pwdata[3:0]; // see R12
    end
  end

  // ready flags sampled so reads of them are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_r <= 8'h00;
    else
      flags_r <= {osc_ready_in, 1'b0, pll_ok}; // see R10
  end

  // oscillator enables: manual or peripheral demand
  genvar g;
  generate
    for (g = 0; g < OSC_NUM; g++) begin : g_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          osc_enable[g] <= 1'b0;
        else
          osc_enable[g] <= man_en_r[g] | periph_request[g]; // see R14
      end
    end
  endgenerate
  // bits 5..0 map ext fast medium slow sec conv; see R15 R16 R17 R18 R19

  // registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_high_power     <= 1'b0;
      fast_internal_frequency  <= FREQ_RESET;
      fast_internal_trim_value <= TRIM_RESET;
      current_source           <= SRC_RESET;
      current_divider          <= DIV_RESET;
      switch_hold_irq          <= 1'b0;
    end else begin
      secondary_high_power     <= spwr_r; // see R6
      fast_internal_frequency  <= freq_r;
      fast_internal_trim_value <= trim_r;
      current_source           <= cur_src_r;
      current_divider          <= cur_div_r;
      switch_hold_irq          <= (state_r == ST_HELD); // see R4
    end
  end

  // apb read data and error, answered in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !idx_ok;
      prdata  <= 32'h0000_0000;
      if (rd_en) begin // refused addresses read as zero
        case (idx)
          IDX_REQ_SRC_DIV: prdata[6:0] <= {req_src_r, req_div_r};
          IDX_CUR_SRC_DIV: prdata[6:0] <= {cur_src_r, cur_div_r};
          // complete and new-ready are live state; see R7 R8 R9
          IDX_HOLD_STATUS: prdata[7:0] <= {hold_r, spwr_r, 1'b0,
                                           !switching,
                                           switching && sel_ready,
                                           3'b000};
          IDX_READY_FLAGS: prdata[7:0] <= flags_r;
          IDX_MANUAL_EN:   prdata[7:0] <= {man_en_r, 2'b00};
          IDX_TRIM:        prdata[5:0] <= trim_r;
          IDX_FREQ_SEL:    prdata[3:0] <= freq_r;
          default:         prdata      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks, all on pclk and quiet during reset
  chk_switch_copies: assert property ( // see R5
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_WAIT && switching && sel_ready && !hold_r
    |=> cur_src_r == $past(req_src_r) && cur_div_r == $past(req_div_r))
    else $error("switch did not copy request");
  chk_hold_pauses: assert property ( // see R4
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_WAIT && switching && sel_ready && hold_r
    |=> state_r == ST_HELD ##1 switch_hold_irq)
    else $error("hold did not pause switch");
  chk_held_stable: assert property ( // see R4
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_HELD && hold_r |=> $stable(cur_src_r))
    else $error("current source moved while held");
  chk_release_hold: assert property ( // see R24
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_HELD && switching && sel_ready && !hold_r
    |=> !switching || $changed(req_src_r) || $changed(req_div_r))
    else $error("release did not complete switch");
  chk_reserved_src: assert property ( // see R21
    @(posedge pclk) disable iff (!presetn)
    wr_en && idx == IDX_REQ_SRC_DIV && !src_legal(pwdata[6:4])
    |=> $stable(req_src_r) && $stable(req_div_r))
    else $error("reserved source was written");
  chk_locked_request: assert property ( // see R22
    @(posedge pclk) disable iff (!presetn)
    !switch_allow_config |=> $stable(req_src_r) && $stable(req_div_r))
    else $error("request changed while locked");
  chk_enable_follow: assert property ( // see R14
    @(posedge pclk) disable iff (!presetn)
    man_en_r[5] |=> osc_enable[5])
    else $error("manual enable ignored");
  chk_pll_flag: assert property ( // see R11
    @(posedge pclk) disable iff (!presetn)
    !pll_enabled |=> !flags_r[0])
    else $error("pll flag set while disabled");
  chk_freq_range: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    freq_r <= FREQ_MAX)
    else $error("frequency code reserved");
  // status bits as read back, one cycle after the setup edge
  chk_done_bit: assert property ( // see R7
    @(posedge pclk) disable iff (!presetn)
    rd_en && idx == IDX_HOLD_STATUS
    |=> prdata[DONE_BIT] == ($past(req_src_r) == $past(cur_src_r) &&
                             $past(req_div_r) == $past(cur_div_r)))
    else $error("switch complete bit wrong");
  chk_newready_bit: assert property ( // see R8
    @(posedge pclk) disable iff (!presetn)
    rd_en && idx == IDX_HOLD_STATUS && !switching |=> !prdata[NRDY_BIT])
    else $error("new ready set outside a switch");
  chk_divider_range: assert property ( // see R1
    @(posedge pclk) disable iff (!presetn)
    req_div_r <= DIV_MAX && cur_div_r <= DIV_MAX)
    else $error("divider code reserved");
  chk_source_legal: assert property ( // see R20
    @(posedge pclk) disable iff (!presetn)
    src_legal(req_src_r) && src_legal(cur_src_r))
    else $error("source code reserved");
  chk_trim_write: assert property ( // see R13
    @(posedge pclk) disable iff (!presetn)
    wr_en && idx == IDX_TRIM |=> trim_r == $past(pwdata[5:0]))
    else $error("trim write lost");
  chk_power_follow: assert property ( // see R6
    @(posedge pclk) disable iff (!presetn)
    spwr_r != secondary_high_power
    |=> secondary_high_power == $past(spwr_r))
    else $error("power select not applied");
  chk_flags_follow: assert property ( // see R10
    @(posedge pclk) disable iff (!presetn)
    flags_r[7:2] != osc_ready_in |=> flags_r[7:2] == $past(osc_ready_in))
    else $error("ready flags not sampled");
  chk_idle_no_irq: assert property ( // see R4
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE |=> !switch_hold_irq)
    else $error("hold interrupt without a held switch");
  chk_freq_reserved: assert property ( // see R12
    @(posedge pclk) disable iff (!presetn)
    wr_en && idx == IDX_FREQ_SEL && pwdata[3:0] > FREQ_MAX
    |=> $stable(freq_r))
    else $error("reserved frequency code stored");
  chk_enable_demand: assert property ( // see R15
    @(posedge pclk) disable iff (!presetn)
    periph_request[4] |=> osc_enable[4])
    else $error("peripheral demand ignored");
  chk_wait_no_copy: assert property ( // see R23
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_WAIT && !sel_ready
    |=> $stable(cur_src_r) && $stable(cur_div_r))
    else $error("switch completed before ready");
endmodule // osc_switch_ctrl

// >>> testbench/oscillator_switch_control_bench.sv
// self-checking bench for the oscillator switch control block
`timescale 1ns/1ns
module oscillator_switch_control_bench;
  import osc_ctrl_pkg::*;
  // apb side
  logic        pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr;
  // oscillator side
  logic        switch_allow_config, pll_enabled, pll_locked;
  logic [5:0]  osc_ready_in, periph_request, osc_enable;
  logic        secondary_high_power, switch_hold_irq;
  logic [3:0]  fast_internal_frequency, current_divider;
  logic [5:0]  fast_internal_trim_value;
  logic [2:0]  current_source;
  // bench state
  int          num_errors, comparisons;
  logic [31:0] rd;
  logic        err;
  logic [5:0]  en, tr;
  logic [3:0]  fq, fexp, d;
  logic [2:0]  bad [3] = '{3'h0, 3'h1, 3'h3};
  logic [2:0]  srcs [5] = '{SRC_EXT, SRC_SEC, SRC_EXT_PLL, SRC_SLOW, SRC_FAST};

  osc_switch_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .switch_allow_config(switch_allow_config), .osc_ready_in(osc_ready_in),
    .pll_enabled(pll_enabled), .pll_locked(pll_locked),
    .periph_request(periph_request), .osc_enable(osc_enable),
    .secondary_high_power(secondary_high_power),
    .fast_internal_frequency(fast_internal_frequency),
    .fast_internal_trim_value(fast_internal_trim_value),
    .current_source(current_source), .current_divider(current_divider),
    .switch_hold_irq(switch_hold_irq));

  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // byte address of a register index
  function automatic logic [31:0] ad(input logic [11:0] idx);
    return {18'h0, idx, 2'h0};
  endfunction
  // reserved frequency codes leave the old one in place
  function automatic logic [3:0] freq_next(input logic [3:0] o, c);
    return (c <= FREQ_MAX) ? c : o;
  endfunction
  // pll needs enable, lock and its external source
  function automatic logic pll_exp();
    return pll_enabled & pll_locked & osc_ready_in[5];
  endfunction

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // data compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // flag compare
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [31:0] a, wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      num_errors++;
      results();
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] v);
    apb(1'b1, ad(idx), {24'h0, v});
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [7:0] e);
    apb(1'b0, ad(idx), 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // let registered copies land
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // bounded wait for the current source and divider
  task automatic wait_cur(input logic [2:0] cs, input logic [3:0] cd);
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      #1;
      if (current_source === cs && current_divider === cd) break;
    end
    chkb(i < 50, 1'b1);
    if (i == 50) results();
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    results();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, pll_enabled, pll_locked} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    switch_allow_config = 1'b1;
    osc_ready_in = 6'h00;
    periph_request = 6'h00;
    presetn = 1'b0;
    void'($urandom(7));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    rdchk(IDX_REQ_SRC_DIV, {1'b0, SRC_RESET, DIV_RESET});
    rdchk(IDX_CUR_SRC_DIV, {1'b0, SRC_RESET, DIV_RESET});
    rdchk(IDX_HOLD_STATUS, 8'h10);
    rdchk(IDX_READY_FLAGS, 8'h00);
    rdchk(IDX_MANUAL_EN, 8'h00);
    rdchk(IDX_TRIM, 8'h00);
    rdchk(IDX_FREQ_SEL, {4'h0, FREQ_RESET});
    // trim extremes and frequency codes, reserved ones included
    fexp = FREQ_RESET;
    for (int k = 0; k < 8; k++) begin
      tr = (k == 0) ? 6'h1F : (k == 1) ? 6'h20 : 6'($urandom);
      fq = (k == 0) ? 4'h8 : (k == 1) ? 4'h9 : 4'($urandom);
      wr(IDX_TRIM, {2'h0, tr});
      wr(IDX_FREQ_SEL, {4'h0, fq});
      fexp = freq_next(fexp, fq);
      settle();
      chk({26'h0, fast_internal_trim_value}, {26'h0, tr});
      chk({28'h0, fast_internal_frequency}, {28'h0, fexp});
      rdchk(IDX_FREQ_SEL, {4'h0, fexp});
    end
    // manual enables ored with peripheral demand
    for (int k = 0; k < 5; k++) begin
      en = (k == 0) ? 6'h3F : 6'($urandom);
      @(posedge pclk);
      periph_request <= (k == 0) ? 6'h00 : 6'($urandom);
      wr(IDX_MANUAL_EN, {en, 2'h0});
      settle();
      chk({26'h0, osc_enable}, {26'h0, en | periph_request});
      rdchk(IDX_MANUAL_EN, {en, 2'h0});
    end
    // ready flags follow the oscillators
    for (int k = 0; k < 5; k++) begin
      @(posedge pclk);
      osc_ready_in <= 6'($urandom);
      pll_enabled <= 1'($urandom);
      pll_locked <= 1'($urandom);
      settle();
      rdchk(IDX_READY_FLAGS, {osc_ready_in, 1'b0, pll_exp()});
    end
    // secondary power select
    wr(IDX_HOLD_STATUS, 8'h40);
    settle();
    chkb(secondary_high_power, 1'b1);
    rdchk(IDX_HOLD_STATUS, 8'h50);
    wr(IDX_HOLD_STATUS, 8'h00);
    settle();
    chkb(secondary_high_power, 1'b0);
    // unheld switch waits for the slow oscillator
    @(posedge pclk);
    osc_ready_in <= 6'h00;
    wr(IDX_REQ_SRC_DIV, {1'b0, SRC_SLOW, 4'h0});
    rdchk(IDX_HOLD_STATUS, 8'h00);
    chkb(current_source === SRC_RESET, 1'b1);
    @(posedge pclk);
    osc_ready_in <= 6'h04;
    wait_cur(SRC_SLOW, 4'h0);
    rdchk(IDX_CUR_SRC_DIV, {1'b0, SRC_SLOW, 4'h0});
    rdchk(IDX_HOLD_STATUS, 8'h10);
    // held switch, then release by clearing the hold
    wr(IDX_HOLD_STATUS, 8'h80);
    wr(IDX_REQ_SRC_DIV, {1'b0, SRC_FAST, DIV_RESET});
    @(posedge pclk);
    osc_ready_in <= 6'h14;
    for (int k = 0; k < 20 && switch_hold_irq !== 1'b1; k++) @(posedge pclk);
    #1;
    chkb(switch_hold_irq, 1'b1);
    chkb(current_source === SRC_SLOW, 1'b1);
    rdchk(IDX_HOLD_STATUS, 8'h88);
    wr(IDX_HOLD_STATUS, 8'h00);
    wait_cur(SRC_FAST, DIV_RESET);
    chkb(switch_hold_irq, 1'b0);
    // reserved sources and dividers are dropped whole
    for (int k = 0; k < 6; k++) begin
      d = 4'hA + 4'($urandom % 6);
      wr(IDX_REQ_SRC_DIV, k < 3 ? {1'b0, bad[k], 4'h1} : {1'b0, SRC_EXT, d});
      rdchk(IDX_REQ_SRC_DIV, {1'b0, SRC_FAST, DIV_RESET});
    end
    // request register locked by configuration
    @(posedge pclk);
    switch_allow_config <= 1'b0;
    wr(IDX_REQ_SRC_DIV, {1'b0, SRC_SLOW, 4'h0});
    rdchk(IDX_REQ_SRC_DIV, {1'b0, SRC_FAST, DIV_RESET});
    @(posedge pclk);
    switch_allow_config <= 1'b1;
    osc_ready_in <= 6'h3F;
    pll_enabled <= 1'b1;
    pll_locked <= 1'b1;
    // every legal source code, divider boundaries among them
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? DIV_MAX : (k == 1) ? 4'h0 : 4'($urandom % 10);
      wr(IDX_REQ_SRC_DIV, {1'b0, srcs[k], d});
      wait_cur(srcs[k], d);
      rdchk(IDX_CUR_SRC_DIV, {1'b0, srcs[k], d});
    end
    // unmapped read and misaligned write are refused
    apb(1'b0, ad(IDX_FREQ_SEL + 12'h1), 32'h0);
    chkb(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, ad(IDX_TRIM) + 32'h1, 32'h15);
    chkb(err, 1'b1);
    rdchk(IDX_TRIM, {2'h0, tr});
    results();
  end
endmodule // oscillator_switch_control_bench
